// ==== src/ccl_defines.svh ====
/*
  Offsets, field positions, reset values and timing counts for the comparator control logic.
  Assumes that it is included by its bare name by each design file that needs the constants.
*/
`ifndef CCL_DEFINES_SVH
`define CCL_DEFINES_SVH

`define CCL_CTRL_STATUS_OFS   8'h50
`define CCL_IO_SPACE_DELTA    8'h20
`define CCL_IO_SPACE_LIMIT    8'h3f
`define CCL_CONV_CTRL_B_OFS   8'h7b
`define CCL_DIN_DISABLE_OFS   8'h7f

`define CCL_CS_DISABLE_BIT    7
`define CCL_CS_BANDGAP_BIT    6
`define CCL_CS_OUTPUT_BIT     5
`define CCL_CS_FLAG_BIT       4
`define CCL_CS_IRQ_EN_BIT     3
`define CCL_CS_CAPTURE_BIT    2
`define CCL_CS_MODE_HI        1
`define CCL_CS_MODE_LO        0

`define CCL_CB_MUX_EN_BIT     6
`define CCL_CB_TRIG_HI        2
`define CCL_CB_TRIG_LO        0

`define CCL_DD_POS_BIT        0
`define CCL_DD_NEG_BIT        1

`define CCL_CTRL_STATUS_RST   8'h00
`define CCL_CONV_CTRL_B_RST   8'h00
`define CCL_DIN_DISABLE_RST   8'h00
`define CCL_READ_ZERO         8'h00

`define CCL_SYNC_STAGES       2

`endif

// ==== src/ccl_pkg.sv ====
/*
  Types shared by the comparator control logic: interrupt modes and trigger sources.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none

package ccl_pkg;

  typedef enum logic [1:0] {
    CCL_MODE_TOGGLE   = 2'h0,
    CCL_MODE_RESERVED = 2'h1,
    CCL_MODE_FALL     = 2'h2,
    CCL_MODE_RISE     = 2'h3
  } ccl_irq_mode_t;

  typedef enum logic [2:0] {
    CCL_TRIG_FREE_RUN   = 3'h0,
    CCL_TRIG_COMPARATOR = 3'h1,
    CCL_TRIG_EXT_INT0   = 3'h2,
    CCL_TRIG_T0_CMP_A   = 3'h3,
    CCL_TRIG_T0_OVF     = 3'h4,
    CCL_TRIG_T1_CMP_B   = 3'h5,
    CCL_TRIG_T1_OVF     = 3'h6,
    CCL_TRIG_T1_CAPTURE = 3'h7
  } ccl_trig_src_t;

endpackage

`default_nettype wire

// ==== src/ccl_sync.sv ====
/*
  A bank of two-flop synchronizers for levels that arrive from outside the clock domain.
  Assumes each bit is a slow level; pulses shorter than one cycle may be missed.
*/
`default_nettype none

module ccl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_a;
  logic [WIDTH-1:0] stage_b;
  logic [WIDTH-1:0] next_stage_a;
  logic [WIDTH-1:0] next_stage_b;

  // Only the second stage reads the first one.
  always_comb begin
    next_stage_a = stage_a;
    next_stage_b = stage_b;
    if (clk_en_in) begin
      next_stage_a = async_in;
      next_stage_b = stage_a;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage_a <= '0;
      stage_b <= '0;
    end else begin
      stage_a <= next_stage_a;
      stage_b <= next_stage_b;
    end
  end

  assign sync_out = stage_b;

endmodule

`default_nettype wire

// ==== src/ccl_trig.sv ====
/*
  Converter auto-trigger source selection and rising-edge detection.
  Assumes every source flag comes from logic on the same clock, so none is synchronized.
*/
`default_nettype none

module ccl_trig
  import ccl_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  input  wire logic       auto_trigger_enable_in,
  input  wire logic       converter_enable_in,
  input  wire logic [2:0] trigger_source_select_in,
  input  wire logic [7:0] source_flags_in,
  output logic            conv_trigger_out
);

  logic selected;
  logic prev_selected;
  logic next_prev_selected;
  logic trigger;
  logic next_trigger;

  function automatic logic ccl_rise(input logic prev, input logic cur);
    ccl_rise = cur & ~prev;
  endfunction

  always_comb begin
    case (ccl_trig_src_t'(trigger_source_select_in))
      CCL_TRIG_FREE_RUN: begin
        selected = 1'b0;
      end
      default: begin
        selected = source_flags_in[trigger_source_select_in];
      end
    endcase
  end

  // The previous value follows the selected signal, so a switch from a clear source to a set one is an edge.
  always_comb begin
    next_prev_selected = prev_selected;
    next_trigger       = trigger;
    if (clk_en_in) begin
      next_prev_selected = selected;
      next_trigger       = auto_trigger_enable_in & converter_enable_in &
                           ccl_rise(prev_selected, selected);
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_selected <= 1'b0;
      trigger       <= 1'b0;
    end else begin
      prev_selected <= next_prev_selected;
      trigger       <= next_trigger;
    end
  end

  assign conv_trigger_out = trigger;

endmodule

`default_nettype wire

// ==== src/ccl_top.sv ====
/*
  Comparator control logic: register file, input selection, result synchronization,
  interrupt flag and request, capture routing, converter trigger and pin input disables.
  Assumes an analog comparator core that reports its result as a raw level, an analog
  mux that follows the selection outputs, and a CPU register port with one-cycle strobes.
*/
`include "ccl_defines.svh"
`default_nettype none

module ccl_top
  import ccl_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       clk_en_in,
  // CPU register port.
  input  wire logic [7:0] bus_addr_in,
  input  wire logic       bus_io_space_in,
  input  wire logic       bus_wr_in,
  input  wire logic       bus_rd_in,
  input  wire logic [7:0] bus_wdata_in,
  output logic      [7:0] bus_rdata_out,
  // Interrupt handshake.
  input  wire logic       global_irq_enable_in,
  input  wire logic       irq_ack_in,
  output logic            irq_req_out,
  // Analog core.
  input  wire logic       comp_raw_in,
  output logic            comparator_power_off_out,
  output logic            bandgap_select_out,
  output logic            negative_mux_select_out,
  output logic      [2:0] negative_channel_out,
  // Converter state.
  input  wire logic       converter_enable_in,
  input  wire logic       auto_trigger_enable_in,
  input  wire logic [2:0] channel_select_low_in,
  input  wire logic       ext_int0_flag_in,
  input  wire logic       t0_compare_a_flag_in,
  input  wire logic       t0_overflow_flag_in,
  input  wire logic       t1_compare_b_flag_in,
  input  wire logic       t1_overflow_flag_in,
  input  wire logic       t1_capture_flag_in,
  output logic            conv_trigger_out,
  // Timer capture front end.
  output logic            capture_source_out,
  // Pins.
  input  wire logic       positive_input_pin_in,
  input  wire logic       negative_input_pin_in,
  output logic            positive_pin_buffer_off_out,
  output logic            negative_pin_buffer_off_out,
  output logic            positive_pin_read_out,
  output logic            negative_pin_read_out
);

  // Control and status fields.
  logic          comparator_disable;
  logic          bandgap_select;
  logic          comparator_irq_flag;
  logic          comparator_irq_enable;
  logic          capture_route_enable;
  ccl_irq_mode_t irq_mode;
  // Conversion control B fields.
  logic          negative_mux_enable;
  logic [2:0]    trigger_source_select;
  // Input disable fields.
  logic          positive_pin_input_disable;
  logic          negative_pin_input_disable;
  // Derived outputs held in flops.
  logic [7:0]    rdata;
  logic          irq_req;
  logic          capture_source;
  logic          mux_select;
  logic [2:0]    negative_channel;
  logic          pos_read;
  logic          neg_read;
  logic          prev_status;

  logic          next_comparator_disable;
  logic          next_bandgap_select;
  logic          next_comparator_irq_flag;
  logic          next_comparator_irq_enable;
  logic          next_capture_route_enable;
  ccl_irq_mode_t next_irq_mode;
  logic          next_negative_mux_enable;
  logic [2:0]    next_trigger_source_select;
  logic          next_positive_pin_input_disable;
  logic          next_negative_pin_input_disable;
  logic [7:0]    next_rdata;
  logic          next_irq_req;
  logic          next_capture_source;
  logic          next_mux_select;
  logic [2:0]    next_negative_channel;
  logic          next_pos_read;
  logic          next_neg_read;
  logic          next_prev_status;

  logic [2:0]    sync_levels;
  logic          comparator_output_status;
  logic          pos_pin_sync;
  logic          neg_pin_sync;
  logic          hit_ctrl_status;
  logic          hit_conv_ctrl_b;
  logic          hit_din_disable;
  logic          edge_event;
  logic          flag_clear;
  logic [7:0]    ctrl_status_view;
  logic [7:0]    conv_ctrl_b_view;
  logic [7:0]    din_disable_view;
  logic [7:0]    source_flags;

  // I/O space addresses sit 0x20 below the data-space offset and cover only 0x00 to 0x3f.
  function automatic logic ccl_hit(input logic [7:0] addr, input logic io_space,
                                   input logic [7:0] offset, input logic io_mapped);
    logic [7:0] data_addr;
    data_addr = 8'(addr + `CCL_IO_SPACE_DELTA);
    if (io_space) begin
      ccl_hit = io_mapped && (addr <= `CCL_IO_SPACE_LIMIT) && (data_addr == offset);
    end else begin
      ccl_hit = (addr == offset);
    end
  endfunction

  function automatic logic ccl_edge(input ccl_irq_mode_t mode, input logic prev,
                                    input logic cur);
    case (mode)
      CCL_MODE_TOGGLE: begin
        ccl_edge = prev ^ cur;
      end
      CCL_MODE_FALL: begin
        ccl_edge = prev & ~cur;
      end
      CCL_MODE_RISE: begin
        ccl_edge = ~prev & cur;
      end
      default: begin
        ccl_edge = 1'b0;
      end
    endcase
  endfunction

  // The analog core raises its raw level when the positive input is above the negative.
  ccl_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({negative_input_pin_in, positive_input_pin_in, comp_raw_in}),
    .sync_out   (sync_levels)
  );

  assign comparator_output_status = sync_levels[0];
  assign pos_pin_sync             = sync_levels[1];
  assign neg_pin_sync             = sync_levels[2];

  assign source_flags = {t1_capture_flag_in, t1_overflow_flag_in, t1_compare_b_flag_in,
                         t0_overflow_flag_in, t0_compare_a_flag_in, ext_int0_flag_in,
                         comparator_irq_flag, 1'b0};

  ccl_trig u_trig (
    .sys_clk_in               (sys_clk_in),
    .nrst_in                  (nrst_in),
    .clk_en_in                (clk_en_in),
    .auto_trigger_enable_in   (auto_trigger_enable_in),
    .converter_enable_in      (converter_enable_in),
    .trigger_source_select_in (trigger_source_select),
    .source_flags_in          (source_flags),
    .conv_trigger_out         (conv_trigger_out)
  );

  always_comb begin
    hit_ctrl_status = ccl_hit(bus_addr_in, bus_io_space_in,
                              `CCL_CTRL_STATUS_OFS, 1'b1);
    hit_conv_ctrl_b = ccl_hit(bus_addr_in, bus_io_space_in, `CCL_CONV_CTRL_B_OFS, 1'b0);
    hit_din_disable = ccl_hit(bus_addr_in, bus_io_space_in, `CCL_DIN_DISABLE_OFS, 1'b0);
    edge_event      = ccl_edge(irq_mode, prev_status, comparator_output_status);
    flag_clear      = irq_ack_in |
                      (bus_wr_in & hit_ctrl_status & bus_wdata_in[`CCL_CS_FLAG_BIT]);
  end

  always_comb begin
    ctrl_status_view = `CCL_READ_ZERO;
    ctrl_status_view[`CCL_CS_DISABLE_BIT] = comparator_disable;
    ctrl_status_view[`CCL_CS_BANDGAP_BIT] = bandgap_select;
    ctrl_status_view[`CCL_CS_OUTPUT_BIT]  = comparator_output_status;
    ctrl_status_view[`CCL_CS_FLAG_BIT]    = comparator_irq_flag;
    ctrl_status_view[`CCL_CS_IRQ_EN_BIT]  = comparator_irq_enable;
    ctrl_status_view[`CCL_CS_CAPTURE_BIT] = capture_route_enable;
    ctrl_status_view[`CCL_CS_MODE_HI:`CCL_CS_MODE_LO] = irq_mode;
    conv_ctrl_b_view = `CCL_READ_ZERO;
    conv_ctrl_b_view[`CCL_CB_MUX_EN_BIT] = negative_mux_enable;
    conv_ctrl_b_view[`CCL_CB_TRIG_HI:`CCL_CB_TRIG_LO] = trigger_source_select;
    din_disable_view = `CCL_READ_ZERO;
    din_disable_view[`CCL_DD_POS_BIT] = positive_pin_input_disable;
    din_disable_view[`CCL_DD_NEG_BIT] = negative_pin_input_disable;
  end

  always_comb begin
    next_comparator_disable         = comparator_disable;
    next_bandgap_select             = bandgap_select;
    next_comparator_irq_flag        = comparator_irq_flag;
    next_comparator_irq_enable      = comparator_irq_enable;
    next_capture_route_enable       = capture_route_enable;
    next_irq_mode                   = irq_mode;
    next_negative_mux_enable        = negative_mux_enable;
    next_trigger_source_select      = trigger_source_select;
    next_positive_pin_input_disable = positive_pin_input_disable;
    next_negative_pin_input_disable = negative_pin_input_disable;
    next_rdata                      = rdata;
    next_irq_req                    = irq_req;
    next_capture_source             = capture_source;
    next_mux_select                 = mux_select;
    next_negative_channel           = negative_channel;
    next_pos_read                   = pos_read;
    next_neg_read                   = neg_read;
    next_prev_status                = prev_status;
    if (clk_en_in) begin
      if (bus_wr_in && hit_ctrl_status) begin
        next_comparator_disable    = bus_wdata_in[`CCL_CS_DISABLE_BIT];
        next_bandgap_select        = bus_wdata_in[`CCL_CS_BANDGAP_BIT];
        next_comparator_irq_enable = bus_wdata_in[`CCL_CS_IRQ_EN_BIT];
        next_capture_route_enable  = bus_wdata_in[`CCL_CS_CAPTURE_BIT];
        next_irq_mode = ccl_irq_mode_t'(bus_wdata_in[`CCL_CS_MODE_HI:`CCL_CS_MODE_LO]);
      end
      if (bus_wr_in && hit_conv_ctrl_b) begin
        next_negative_mux_enable   = bus_wdata_in[`CCL_CB_MUX_EN_BIT];
        next_trigger_source_select = bus_wdata_in[`CCL_CB_TRIG_HI:`CCL_CB_TRIG_LO];
      end
      if (bus_wr_in && hit_din_disable) begin
        next_positive_pin_input_disable = bus_wdata_in[`CCL_DD_POS_BIT];
        next_negative_pin_input_disable = bus_wdata_in[`CCL_DD_NEG_BIT];
      end
      // A new edge in the clearing cycle keeps the flag set.
      next_comparator_irq_flag = edge_event | (comparator_irq_flag & ~flag_clear);
      next_prev_status = comparator_output_status;
      // The request follows the next flag state, so it changes with the flag and an ack drops it at once.
      next_irq_req = next_comparator_irq_flag & comparator_irq_enable &
                     global_irq_enable_in;
      next_capture_source = capture_route_enable & comparator_output_status;
      next_mux_select = negative_mux_enable & ~converter_enable_in;
      next_negative_channel = channel_select_low_in;
      next_pos_read = pos_pin_sync & ~positive_pin_input_disable;
      next_neg_read = neg_pin_sync & ~negative_pin_input_disable;
      if (bus_rd_in) begin
        if (hit_ctrl_status) begin
          next_rdata = ctrl_status_view;
        end else if (hit_conv_ctrl_b) begin
          next_rdata = conv_ctrl_b_view;
        end else if (hit_din_disable) begin
          next_rdata = din_disable_view;
        end else begin
          next_rdata = `CCL_READ_ZERO;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      comparator_disable         <= 1'(`CCL_CTRL_STATUS_RST >> `CCL_CS_DISABLE_BIT);
      bandgap_select             <= 1'b0;
      comparator_irq_flag        <= 1'b0;
      comparator_irq_enable      <= 1'b0;
      capture_route_enable       <= 1'b0;
      irq_mode                   <= CCL_MODE_TOGGLE;
      negative_mux_enable        <= 1'b0;
      trigger_source_select      <= 3'h0;
      positive_pin_input_disable <= 1'b0;
      negative_pin_input_disable <= 1'b0;
      rdata                      <= `CCL_READ_ZERO;
      irq_req                    <= 1'b0;
      capture_source             <= 1'b0;
      mux_select                 <= 1'b0;
      negative_channel           <= 3'h0;
      pos_read                   <= 1'b0;
      neg_read                   <= 1'b0;
      prev_status                <= 1'b0;
    end else begin
      comparator_disable         <= next_comparator_disable;
      bandgap_select             <= next_bandgap_select;
      comparator_irq_flag        <= next_comparator_irq_flag;
      comparator_irq_enable      <= next_comparator_irq_enable;
      capture_route_enable       <= next_capture_route_enable;
      irq_mode                   <= next_irq_mode;
      negative_mux_enable        <= next_negative_mux_enable;
      trigger_source_select      <= next_trigger_source_select;
      positive_pin_input_disable <= next_positive_pin_input_disable;
      negative_pin_input_disable <= next_negative_pin_input_disable;
      rdata                      <= next_rdata;
      irq_req                    <= next_irq_req;
      capture_source             <= next_capture_source;
      mux_select                 <= next_mux_select;
      negative_channel           <= next_negative_channel;
      pos_read                   <= next_pos_read;
      neg_read                   <= next_neg_read;
      prev_status                <= next_prev_status;
    end
  end

  assign bus_rdata_out               = rdata;
  assign irq_req_out                 = irq_req;
  assign comparator_power_off_out    = comparator_disable;
  assign bandgap_select_out          = bandgap_select;
  assign negative_mux_select_out     = mux_select;
  assign negative_channel_out        = negative_channel;
  assign capture_source_out          = capture_source;
  assign positive_pin_buffer_off_out = positive_pin_input_disable;
  assign negative_pin_buffer_off_out = negative_pin_input_disable;
  assign positive_pin_read_out       = pos_read;
  assign negative_pin_read_out       = neg_read;

endmodule

`default_nettype wire

// ==== bench/ccl_checker.sv ====
/*
  Port-level assertions for ccl_top.
  Assumes clk_en_in stays high wherever a rule is exercised, and one-cycle register latency.
*/
`default_nettype none
module ccl_checker (
  input wire logic       sys_clk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic       bus_io_space_in,
  input wire logic       bus_rd_in,
  input wire logic [7:0] bus_rdata_out,
  input wire logic       global_irq_enable_in,
  input wire logic       irq_ack_in,
  input wire logic       irq_req_out,
  input wire logic       comp_raw_in,
  input wire logic       converter_enable_in,
  input wire logic       auto_trigger_enable_in,
  input wire logic [2:0] channel_select_low_in,
  input wire logic       negative_mux_select_out,
  input wire logic [2:0] negative_channel_out,
  input wire logic       conv_trigger_out,
  input wire logic       positive_pin_buffer_off_out,
  input wire logic       positive_pin_read_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [2:0] quiet;
  logic       miss;
  // An edge still in the synchronizer may re-set the flag, so acks count only when quiet.
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in) quiet <= 3'h0;
    else if ($changed(comp_raw_in)) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  assign miss = bus_io_space_in ? (bus_addr_in != 8'h30)
                                : !(bus_addr_in inside {8'h50, 8'h7b, 8'h7f});
  irq_global_a: assert property (irq_req_out |-> $past(global_irq_enable_in))
    else $error("request without global enable");
  ack_clear_a: assert property (irq_ack_in && quiet == 3'h7 |=> !irq_req_out)
    else $error("request kept after ack");
  trig_pulse_a: assert property (conv_trigger_out |=> !conv_trigger_out)
    else $error("trigger longer than one cycle");
  trig_gate_a: assert property (conv_trigger_out |->
    $past(auto_trigger_enable_in && converter_enable_in)) else $error("trigger while gated");
  mux_gate_a: assert property (negative_mux_select_out |-> $past(!converter_enable_in))
    else $error("mux lent while converter on");
  chan_copy_a: assert property (negative_mux_select_out |->
    negative_channel_out == $past(channel_select_low_in)) else $error("wrong channel");
  pin_off_a: assert property (positive_pin_buffer_off_out &&
    $past(positive_pin_buffer_off_out) |-> !positive_pin_read_out) else $error("pin read");
  unmapped_rd_a: assert property (bus_rd_in && miss |=> bus_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cover property (irq_req_out);
  cover property (conv_trigger_out);
  cover property (negative_mux_select_out);
endmodule
bind ccl_top ccl_checker u_chk (.sys_clk_in, .nrst_in, .bus_addr_in, .bus_io_space_in,
  .bus_rd_in, .bus_rdata_out, .global_irq_enable_in, .irq_ack_in, .irq_req_out, .comp_raw_in,
  .converter_enable_in, .auto_trigger_enable_in, .channel_select_low_in,
  .negative_mux_select_out, .negative_channel_out, .conv_trigger_out,
  .positive_pin_buffer_off_out, .positive_pin_read_out);
`default_nettype wire

// ==== bench/ccl_top_tb_top.sv ====
/*
  Self-checking bench for ccl_top: registers, input selection, interrupt, capture, trigger.
  Assumes one-cycle register strobes and registered read data.
*/
`default_nettype none
module ccl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, nrst_in, bus_io_space_in, bus_wr_in, bus_rd_in, global_irq_enable_in;
  logic irq_ack_in, irq_req_out, comp_raw_in, comparator_power_off_out, bandgap_select_out;
  logic negative_mux_select_out, converter_enable_in, auto_trigger_enable_in, conv_trigger_out;
  logic ext_int0_flag_in, t0_compare_a_flag_in, t0_overflow_flag_in, t1_compare_b_flag_in;
  logic t1_overflow_flag_in, t1_capture_flag_in, capture_source_out, positive_input_pin_in;
  logic negative_input_pin_in, positive_pin_buffer_off_out, negative_pin_buffer_off_out;
  logic positive_pin_read_out, negative_pin_read_out, m_fl;
  logic [7:0]  bus_addr_in, bus_wdata_in, bus_rdata_out, m_cs, m_cb, m_dd;
  logic [2:0]  channel_select_low_in, negative_channel_out;
  logic [31:0] seed, r;
  logic        clk_en_in = 1'b1;
  int          fails, checks_done, cycles, trig_cnt, ns;
  ccl_top uut (.sys_clk_in, .nrst_in, .clk_en_in, .bus_addr_in, .bus_io_space_in, .bus_wr_in,
    .bus_rd_in, .bus_wdata_in, .bus_rdata_out, .global_irq_enable_in, .irq_ack_in,
    .irq_req_out, .comp_raw_in, .comparator_power_off_out, .bandgap_select_out,
    .negative_mux_select_out, .negative_channel_out, .converter_enable_in,
    .auto_trigger_enable_in, .channel_select_low_in, .ext_int0_flag_in, .t0_compare_a_flag_in,
    .t0_overflow_flag_in, .t1_compare_b_flag_in, .t1_overflow_flag_in, .t1_capture_flag_in,
    .conv_trigger_out, .capture_source_out, .positive_input_pin_in, .negative_input_pin_in,
    .positive_pin_buffer_off_out, .negative_pin_buffer_off_out, .positive_pin_read_out,
    .negative_pin_read_out);
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #2;
  endtask
  task give_verdict();
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // The idle cycle at the end keeps a strobe from being driven twice in one step.
  task acc(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    {bus_wr_in, bus_rd_in, bus_io_space_in, bus_addr_in, bus_wdata_in} = {w, !w, io, a, d};
    tick(1);
    {bus_wr_in, bus_rd_in} = 2'h0;
    tick(1);
  endtask
  task rd(input string nm, input logic io, input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, io, a, 8'h00);
    chk(nm, bus_rdata_out, exp);
  endtask
  task flags(input logic [5:0] v);
    {t1_capture_flag_in, t1_overflow_flag_in, t1_compare_b_flag_in, t0_overflow_flag_in,
     t0_compare_a_flag_in, ext_int0_flag_in} = v;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles++;
    if (conv_trigger_out === 1'b1) trig_cnt++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    {bus_addr_in, bus_io_space_in, bus_wr_in, bus_rd_in, bus_wdata_in, global_irq_enable_in,
     irq_ack_in, comp_raw_in, converter_enable_in, auto_trigger_enable_in, nrst_in} = '0;
    {channel_select_low_in, positive_input_pin_in, negative_input_pin_in} = '0;
    flags(6'h00);
    seed = 32'h187f;
    tick(10);
    nrst_in = 1'b1;
    rd("ctl", 1'b1, 8'h30, 8'h00);
    rd("miss", 1'b1, 8'h50, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      {m_cb, m_dd, m_cs} = {r[7:0] & 8'h47, r[15:8] & 8'h03, r[23:16] & 8'hc7};
      acc(1'b1, 1'b0, 8'h7b, r[7:0]);
      acc(1'b1, 1'b0, 8'h7f, r[15:8]);
      acc(1'b1, 1'b1, 8'h30, r[23:16] & 8'hc7);
      {positive_input_pin_in, negative_input_pin_in, converter_enable_in} = r[26:24];
      channel_select_low_in = i[2:0];
      rd("ctl_b", 1'b0, 8'h7b, m_cb);
      rd("dis", 1'b0, 8'h7f, m_dd);
      rd("ctl", 1'b0, 8'h50, m_cs);
      chk("off", 8'(comparator_power_off_out), 8'(m_cs[7]));
      chk("bg", 8'(bandgap_select_out), 8'(m_cs[6]));
      chk("prd", 8'(positive_pin_read_out), 8'(positive_input_pin_in & !m_dd[0]));
      chk("nrd", 8'(negative_pin_read_out), 8'(negative_input_pin_in & !m_dd[1]));
      chk("msel", 8'(negative_mux_select_out), 8'(m_cb[6] & !converter_enable_in));
      chk("chan", 8'(negative_channel_out), 8'(i[2:0]));
      chk("boff", 8'({negative_pin_buffer_off_out, positive_pin_buffer_off_out}), m_dd);
    end
    acc(1'b1, 1'b0, 8'h7b, 8'h01);
    {global_irq_enable_in, auto_trigger_enable_in, converter_enable_in} = 3'h7;
    for (int md = 0; md < 4; md++) begin
      acc(1'b1, 1'b0, 8'h50, 8'(16 + md));
      acc(1'b1, 1'b0, 8'h50, 8'(12 + md));
      trig_cnt = 0;
      ns = 0;
      for (int e = 0; e < 2; e++) begin
        comp_raw_in = !comp_raw_in;
        tick(8);
        m_fl = (md == 0 || md == (comp_raw_in ? 3 : 2));
        ns += int'(m_fl);
        chk("req", 8'(irq_req_out), 8'(m_fl));
        chk("cap", 8'(capture_source_out), 8'(comp_raw_in));
        rd("st", 1'b1, 8'h30, {2'h0, comp_raw_in, m_fl, 4'(12 + md)});
        irq_ack_in = (e == 0);
        tick(1);
        irq_ack_in = 1'b0;
        if (e == 1) acc(1'b1, 1'b0, 8'h50, 8'(16 + md));
        tick(1);
        chk("clr", 8'(irq_req_out), 8'h00);
      end
      chk("trig1", 8'(trig_cnt), 8'(ns));
    end
    {global_irq_enable_in, auto_trigger_enable_in} = 2'h0;
    acc(1'b1, 1'b0, 8'h50, 8'h10);
    acc(1'b1, 1'b0, 8'h50, 8'h18);
    trig_cnt = 0;
    comp_raw_in = 1'b1;
    tick(8);
    chk("mask", 8'(irq_req_out), 8'h00);
    chk("capoff", 8'(capture_source_out), 8'h00);
    chk("gate", 8'(trig_cnt), 8'h00);
    rd("fl", 1'b0, 8'h50, 8'h38);
    global_irq_enable_in = 1'b1;
    auto_trigger_enable_in = 1'b1;
    acc(1'b1, 1'b0, 8'h7b, 8'h00);
    trig_cnt = 0;
    acc(1'b1, 1'b0, 8'h7b, 8'h01);
    tick(1);
    chk("gie", 8'(irq_req_out), 8'h01);
    chk("sw", 8'(trig_cnt), 8'h01);
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 1'b0, 8'h7b, 8'(c | 2 * int'(c == 1)));
      trig_cnt = 0;
      flags(6'h3f);
      tick(3);
      flags(6'h00);
      tick(2);
      chk("src", 8'(trig_cnt), 8'(c != 0));
    end
    // A write while the clock enable is low must leave the register untouched.
    clk_en_in = 1'b0;
    acc(1'b1, 1'b0, 8'h7f, ~m_dd);
    clk_en_in = 1'b1;
    rd("frz", 1'b0, 8'h7f, m_dd);
    give_verdict();
  end
endmodule
`default_nettype wire
